// >>> hdl/jesd_rx_delay_and_transport.sv
// receive multiframe alignment, release buffer, latency readback and transport unpacking
`timescale 1ns/1ps
//
// Summary of operation
// - readable latency from local multiframe to data
// - processing clock is lane byte rate/4
// - frame cycles per processing cycle is 4/F
// - receiver adds fixed 12, variable 2 cycles
// - transport unpacks frames into 16-bit samples
// - octets per frame only 1, 2, 4
// - frames per multiframe fixed at 32
// - lanes per link four or eight
// - converters one real, two complex
// - samples per converter per frame one/two
// - control words and bits must be zero
// - resolution and bits per sample sixteen
// - local multiframe clock delayed by programmed delay
// - release buffer delay clamps to 0..10
module jesd_rx_delay_and_transport
   import jesd_rx_pkg::*;
#(
   parameter int LANES     = 8,
   parameter int BUF_DEPTH = 64
)
(
   // clock and reset
   input  wire logic                          core_clk,
   input  wire logic                          resetn,
   // apb slave
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [15:0]                   paddr,
   input  wire logic [31:0]                   pwdata,
   output logic      [31:0]                   prdata,
   output logic                               pready,
   output logic                               pslverr,
   // link layer side, descrambled lane words, same clock
   input  wire logic                          sysref_mf_pulse,
   input  wire logic                          lane_valid,
   input  wire logic                          ilas_end,
   input  wire logic [LANES*32-1:0]           lane_data,
   // sample output
   output logic                               dac_sample_valid,
   output logic [LANES*2*SAMPLE_BITS-1:0]     dac_samples,
   output logic [5:0]                         dac_sample_count,
   output logic                               lmfc_rx_pulse,
   output logic                               lane_align_config_error_flag
);

   localparam int WORD_W = LANES * 32;
   localparam int PTR_W  = $clog2(BUF_DEPTH);

   // -------------------------------------------------
   // helpers
   // -------------------------------------------------
   // cycles per multiframe = K / (4/F)
   function automatic logic [5:0] mf_cycles(input logic [2:0] f);
      logic [5:0] r;
      r = 6'(K_FRAMES * 32'(f) / BYTES_PER_PCLK);
      return (r == 6'h00) ? 6'h08 : r;
   endfunction

   function automatic logic map_hit(input logic [15:0] a);
      logic [15:0] i;
      i = {2'h0, a[15:2]};
      return (a[1:0] == 2'h0) &&
             (i == IDX_LINK_CTRL || i == IDX_LATENCY || i == IDX_MF_DELAY ||
              i == IDX_VAR_BUDGET || i == IDX_LINK_PARAMS || i == IDX_LINK_STATUS);
   endfunction

   // -------------------------------------------------
   // register bus
   // -------------------------------------------------
   logic [15:0] reg_idx;
   logic        wr_en;
   logic        link_en_reg;
   logic [7:0]  mf_delay_reg;
   logic [7:0]  var_budget_reg;
   logic [31:0] link_params_reg;
   logic [7:0]  latency_reg;
   logic        cfg_err_reg;
   rx_state_t   state_reg;

   assign reg_idx = {2'h0, paddr[15:2]};
   assign wr_en   = psel && penable && pwrite && map_hit(paddr);
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !map_hit(paddr);

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         link_en_reg     <= 1'b0;
         mf_delay_reg    <= MF_DELAY_RST;
         var_budget_reg  <= VAR_BUDGET_RST;
         link_params_reg <= LINK_PARAMS_RST;
      end
      else if (wr_en)
      begin
         if (reg_idx == IDX_LINK_CTRL)   link_en_reg     <= pwdata[0];
         if (reg_idx == IDX_MF_DELAY)    mf_delay_reg    <= pwdata[7:0];
         if (reg_idx == IDX_VAR_BUDGET)  var_budget_reg  <= pwdata[7:0];
         if (reg_idx == IDX_LINK_PARAMS) link_params_reg <= pwdata;
      end
   end

   // read data loaded in the setup cycle, valid during access
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         prdata <= 32'h0000_0000;
      else if (psel && !penable)
      begin
         case (reg_idx)
            IDX_LINK_CTRL:   prdata <= {31'h0, link_en_reg};
            IDX_LATENCY:     prdata <= {24'h0, latency_reg};
            IDX_MF_DELAY:    prdata <= {24'h0, mf_delay_reg};
            IDX_VAR_BUDGET:  prdata <= {24'h0, var_budget_reg};
            IDX_LINK_PARAMS: prdata <= link_params_reg;
            IDX_LINK_STATUS: prdata <= {30'h0, state_reg == ST_RUN, cfg_err_reg};
            default:         prdata <= 32'h0000_0000;
         endcase
      end
   end

   // -------------------------------------------------
   // parameter check
   // -------------------------------------------------
   logic [2:0] p_f;
   logic [3:0] p_l;
   logic [1:0] p_m;
   logic [1:0] p_s;
   logic       cfg_bad;

   assign p_f = link_params_reg[F_LSB +: 3];
   assign p_l = link_params_reg[L_LSB +: 4];
   assign p_m = link_params_reg[M_LSB +: 2];
   assign p_s = link_params_reg[S_LSB +: 2];
   assign cfg_bad = !(p_f == 3'd1 || p_f == 3'd2 || p_f == 3'd4)
                 || (link_params_reg[K_LSB +: 5] != 5'(K_FRAMES - 1))
                 || !(p_l == 4'd4 || p_l == 4'd8)
                 || !(p_m == 2'd1 || p_m == 2'd2)
                 || !(p_s == 2'd1 || p_s == 2'd2)
                 || (link_params_reg[CF_LSB +: 2] != 2'h0)
                 || (link_params_reg[CS_LSB +: 2] != 2'h0)
                 || !link_params_reg[HD_BIT]
                 || (link_params_reg[N_LSB +: 4] != 4'(SAMPLE_BITS - 1))
                 || (link_params_reg[NP_LSB +: 4] != 4'(SAMPLE_BITS - 1));

   // -------------------------------------------------
   // receiver fixed pipeline
   // -------------------------------------------------
   logic [WORD_W-1:0] pipe_data  [RX_FIXED_DLY];
   logic              pipe_valid [RX_FIXED_DLY];
   logic              pipe_ilas  [RX_FIXED_DLY];
   logic              dly_valid;
   logic              dly_ilas;

   // fixed receive latency ahead of the release buffer
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         for (int i = 0; i < RX_FIXED_DLY; i++)
         begin
            pipe_data[i]  <= '0;
            pipe_valid[i] <= 1'b0;
            pipe_ilas[i]  <= 1'b0;
         end
      end
      else
      begin
         pipe_data[0]  <= lane_data;
         pipe_valid[0] <= lane_valid;
         pipe_ilas[0]  <= ilas_end;
         for (int i = 1; i < RX_FIXED_DLY; i++)
         begin
            pipe_data[i]  <= pipe_data[i-1];
            pipe_valid[i] <= pipe_valid[i-1];
            pipe_ilas[i]  <= pipe_ilas[i-1];
         end
      end
   end
   assign dly_valid = pipe_valid[RX_FIXED_DLY-1];
   assign dly_ilas  = pipe_ilas[RX_FIXED_DLY-1];

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         cfg_err_reg <= 1'b0;
      else if (dly_ilas && cfg_bad)
         cfg_err_reg <= 1'b1;
      else if (wr_en && reg_idx == IDX_LINK_STATUS && pwdata[0])
         cfg_err_reg <= 1'b0;
   end
   assign lane_align_config_error_flag = cfg_err_reg;

   // -------------------------------------------------
   // local multiframe clock and latency
   // -------------------------------------------------
   logic [5:0] period;
   logic [5:0] del_eff;
   logic [5:0] sys_phase_reg;
   logic [5:0] rx_phase_reg;
   logic [3:0] budget_eff;

   assign period     = mf_cycles(p_f);
   assign del_eff    = 6'(mf_delay_reg) & (period - 6'd1);
   assign budget_eff = (var_budget_reg > 8'(MAX_BUF_DLY)) ? 4'(MAX_BUF_DLY) : var_budget_reg[3:0];
   assign lmfc_rx_pulse = (sys_phase_reg == del_eff);

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         sys_phase_reg <= 6'h00;
      else if (sysref_mf_pulse || sys_phase_reg >= period - 6'd1)
         sys_phase_reg <= 6'h00;
      else
         sys_phase_reg <= sys_phase_reg + 6'd1;
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         rx_phase_reg <= 6'h00;
      else if (lmfc_rx_pulse || rx_phase_reg >= period - 6'd1)
         rx_phase_reg <= 6'h00;
      else
         rx_phase_reg <= rx_phase_reg + 6'd1;
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         latency_reg <= 8'h00;
      else if (dly_ilas)
         latency_reg <= {2'h0, rx_phase_reg};
   end

   // -------------------------------------------------
   // release buffer
   // -------------------------------------------------
   logic [WORD_W-1:0] buf_mem [BUF_DEPTH];
   logic [PTR_W-1:0]  wr_ptr_reg;
   logic [PTR_W-1:0]  rd_ptr_reg;
   logic [PTR_W-1:0]  wr_addr;
   logic [3:0]        hold_cnt_reg;

   // first data word always lands in slot zero
   assign wr_addr = dly_ilas ? '0 : wr_ptr_reg;

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_reg    <= ST_IDLE;
         hold_cnt_reg <= 4'h0;
      end
      else if (!link_en_reg)
         state_reg <= ST_IDLE;
      else
      begin
         case (state_reg)
            ST_IDLE:
               if (dly_ilas)
                  state_reg <= ST_ARMED;
            ST_ARMED:
               if (lmfc_rx_pulse)
               begin
                  hold_cnt_reg <= budget_eff;
                  state_reg    <= (budget_eff == 4'h0) ? ST_RUN : ST_HOLD;
               end
            ST_HOLD:
            begin
               hold_cnt_reg <= hold_cnt_reg - 4'h1;
               if (hold_cnt_reg == 4'h1)
                  state_reg <= ST_RUN;
            end
            ST_RUN:
               if (dly_ilas)
                  state_reg <= ST_ARMED;
            default:
               state_reg <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         wr_ptr_reg <= '0;
      else if (dly_ilas)
         wr_ptr_reg <= PTR_W'(1);
      else if (dly_valid && state_reg != ST_IDLE)
         wr_ptr_reg <= wr_ptr_reg + PTR_W'(1);
   end

   always_ff @(posedge core_clk)
   begin
      if (dly_valid)
         buf_mem[wr_addr] <= pipe_data[RX_FIXED_DLY-1];
   end

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
         rd_ptr_reg <= '0;
      else if (state_reg != ST_RUN)
         rd_ptr_reg <= '0;
      else
         rd_ptr_reg <= rd_ptr_reg + PTR_W'(1); // all lanes leave together
   end

   // -------------------------------------------------
   // transport unpacking, octet pairs msb first
   // -------------------------------------------------
   logic [WORD_W-1:0] rd_word;
   assign rd_word = buf_mem[rd_ptr_reg];

   generate
      for (genvar i = 0; i < LANES * 2; i++)
      begin : g_unpack
         always_ff @(posedge core_clk or negedge resetn)
         begin
            if (!resetn)
               dac_samples[i*SAMPLE_BITS +: SAMPLE_BITS] <= '0;
            else if (state_reg == ST_RUN)
               dac_samples[i*SAMPLE_BITS +: SAMPLE_BITS] <= {rd_word[(i/2)*32 + 31 - (i%2)*16 -: 8],
                                                             rd_word[(i/2)*32 + 23 - (i%2)*16 -: 8]};
         end
      end
   endgenerate

   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         dac_sample_valid <= 1'b0;
         dac_sample_count <= 6'h00;
      end
      else
      begin
         dac_sample_valid <= (state_reg == ST_RUN) && !cfg_bad;
         dac_sample_count <= {1'b0, p_l, 1'b0};
      end
   end

   // -------------------------------------------------
   // checks
   // -------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);

   sequence s_arm_at_boundary;
      state_reg == ST_ARMED && lmfc_rx_pulse && budget_eff == 4'h3;
   endsequence
   sequence s_three_cycle_hold;
      (state_reg == ST_HOLD) [*3] ##1 (state_reg == ST_RUN);
   endsequence

   a_release_after_budget: assert property ((s_arm_at_boundary and (link_en_reg && !dly_ilas))
      ##1 link_en_reg [*3] |-> state_reg == ST_HOLD) else $error("release too early");
   a_hold_sequence: assert property ((s_arm_at_boundary and link_en_reg) ##1 link_en_reg [*3]
      |-> $past(state_reg, 2) == ST_HOLD && state_reg == ST_HOLD ##1 state_reg == ST_RUN)
      else $error("hold length wrong");
   a_budget_clamped: assert property (budget_eff <= 4'd10) else $error("budget over ten");
   a_local_mf_delay: assert property (sysref_mf_pulse && del_eff == 6'h03 && period > 6'd4
      ##1 (del_eff == 6'h03 && period > 6'd4) [*4] |-> lmfc_rx_pulse) else $error("local multiframe not delayed");
   a_latency_capture: assert property (dly_ilas |=> latency_reg == {2'h0, $past(rx_phase_reg)})
      else $error("latency not captured");
   a_fixed_delay: assert property (lane_valid |-> ##12 dly_valid) else $error("fixed delay not 12");
   a_hd_error: assert property (dly_ilas && !link_params_reg[HD_BIT] |=> lane_align_config_error_flag)
      else $error("hd error not flagged");
   a_param_bad_f: assert property (p_f == 3'd3 |-> cfg_bad) else $error("bad f accepted");
   a_no_output_bad: assert property (cfg_bad |=> !dac_sample_valid) else $error("samples with bad params");
   a_unmapped_err: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr && pready)
      else $error("unmapped not refused");

endmodule // jesd_rx_delay_and_transport

// >>> hdl/jesd_rx_pkg.sv
// shared constants for the receive alignment and transport block
package jesd_rx_pkg;
   // register indices; byte address is four times the index
   localparam logic [15:0] IDX_LINK_CTRL     = 16'h0300;
   localparam logic [15:0] IDX_LATENCY       = 16'h0302;
   localparam logic [15:0] IDX_MF_DELAY      = 16'h0304;
   localparam logic [15:0] IDX_VAR_BUDGET    = 16'h0306;
   localparam logic [15:0] IDX_LINK_PARAMS   = 16'h0310;
   localparam logic [15:0] IDX_LINK_STATUS   = 16'h0312;
   // link parameter field positions
   localparam int F_LSB  = 0;
   localparam int K_LSB  = 3;
   localparam int L_LSB  = 8;
   localparam int M_LSB  = 12;
   localparam int S_LSB  = 14;
   localparam int HD_BIT = 16;
   localparam int CF_LSB = 17;
   localparam int CS_LSB = 19;
   localparam int N_LSB  = 21;
   localparam int NP_LSB = 25;
   // reset values
   localparam logic [31:0] LINK_PARAMS_RST = 32'h1fe158f9;
   localparam logic [7:0]  MF_DELAY_RST    = 8'h00;
   localparam logic [7:0]  VAR_BUDGET_RST  = 8'h00;
   // fixed link parameters and receiver timing in processing-clock cycles
   localparam int K_FRAMES       = 32;
   localparam int BYTES_PER_PCLK = 4;
   localparam int RX_FIXED_DLY   = 12;
   localparam int RX_VAR_DLY     = 2;
   localparam int MAX_BUF_DLY    = 10;
   localparam int SAMPLE_BITS    = 16;
   typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_HOLD, ST_RUN} rx_state_t;
endpackage

// >>> sim/jesd_tx_model.sv
// transmitter-side model driving sysref, ilas and lane words
`timescale 1ns/1ps
module jesd_tx_model
#(
   parameter int LANES = 8
)
(
   // clock and reset
   input  wire logic             core_clk,
   input  wire logic             resetn,
   // bench control
   input  wire logic             go,
   // link side
   output logic                  sysref_mf_pulse,
   output logic                  lane_valid,
   output logic                  ilas_end,
   output logic [LANES*32-1:0]   lane_data
);
   logic [4:0]  sref_reg;
   logic [15:0] seq_reg;
   // ------------------------------
   // framing
   // ------------------------------
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         sref_reg <= 5'h00;
         seq_reg  <= 16'h0000;
      end
      else
      begin
         sref_reg <= sref_reg + 5'h01;
         if (!go)
            seq_reg <= 16'h0000;
         else if (seq_reg != 16'h0000 || sref_reg == 5'h04)
            seq_reg <= seq_reg + 16'h0001;
      end
   end
   // sysref every 32 cycles, a whole number of multiframes
   assign sysref_mf_pulse = (sref_reg == 5'h01);
   assign lane_valid      = (seq_reg != 16'h0000);
   assign ilas_end        = (seq_reg == 16'h0005);
   always_comb
   begin
      for (int l = 0; l < LANES; l++)
      begin
         if (seq_reg >= 16'h0005)
            lane_data[l*32 +: 32] = {seq_reg[7:0] - 8'h05, 8'(l), seq_reg[7:0] + 8'h30, 8'(l) ^ 8'ha5};
         else if (lane_valid)
            lane_data[l*32 +: 32] = {4{8'h7c}};
         else
            lane_data[l*32 +: 32] = {32{sref_reg[0]}};
      end
   end
endmodule // jesd_tx_model

// >>> sim/tb_top.sv
// self-checking bench for receive alignment and transport
`timescale 1ns/1ps
module tb_top
   import jesd_rx_pkg::*;
;
   localparam logic [31:0] PRM = LINK_PARAMS_RST;
   localparam int FT [7] = '{1, 1, 1, 2, 2, 4, 4};
   localparam int DT [7] = '{0, 3, 13, 0, 13, 0, 20};
   localparam logic [31:0] GOOD [3] = '{32'h1fe154f9, 32'h1fe168f9, 32'h1fe198f9};
   localparam logic [31:0] BAD [7] = '{32'h1fe058f9, 32'h1fe358f9, 32'h1fe958f9, 32'h1fe158fb,
                                       32'h1fe158f1, 32'h1fc158f9, 32'h1fe155f9};
   logic         core_clk;
   logic         resetn;
   logic         psel;
   logic         penable;
   logic         pwrite;
   logic [15:0]  paddr;
   logic [31:0]  pwdata;
   logic [31:0]  prdata;
   logic         pready;
   logic         pslverr;
   logic         go;
   logic         sysref_mf_pulse;
   logic         lane_valid;
   logic         ilas_end;
   logic [255:0] lane_data;
   logic         dac_sample_valid;
   logic [511:0] dac_samples;
   logic [5:0]   dac_sample_count;
   logic         lmfc_rx_pulse;
   logic         lane_align_config_error_flag;
   logic [31:0]  rd;
   logic         err;
   int           fail_count;
   int           checked;

   jesd_rx_delay_and_transport u_dut
   (
      .core_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .sysref_mf_pulse, .lane_valid, .ilas_end, .lane_data, .dac_sample_valid, .dac_samples,
      .dac_sample_count, .lmfc_rx_pulse, .lane_align_config_error_flag
   );
   jesd_tx_model u_tx
   (
      .core_clk, .resetn, .go, .sysref_mf_pulse, .lane_valid, .ilas_end, .lane_data
   );

   initial
   begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   // ------------------------------
   // helpers
   // ------------------------------
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic bound_hit;
      fail_count++;
      $display("mismatch at %0t: wait ran out", $time);
      stop_test();
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("mismatch at %0t: got %0h want %0h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
      int n;
      @(posedge core_clk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge core_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (n >= 20)
         bound_hit();
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic count_to(ref logic s, output int n);
      n = 1;
      @(negedge core_clk);
      for (; n < 200 && s !== 1'b1; n++)
         @(negedge core_clk);
      if (n >= 200)
         bound_hit();
   endtask
   function automatic logic [31:0] exp_word(input int k, input int l);
      return {8'(k) + 8'h35, 8'(l) ^ 8'ha5, 8'(k), 8'(l)};
   endfunction
   task automatic run_link(input logic [31:0] prm, input int del, input int bud, output int lat, output int rel);
      int n;
      int nl;
      nl = int'(prm[11:8]);
      apb(1'b1, IDX_LINK_CTRL << 2, 32'h0);
      apb(1'b1, IDX_LINK_PARAMS << 2, prm);
      apb(1'b1, IDX_MF_DELAY << 2, del);
      apb(1'b1, IDX_VAR_BUDGET << 2, bud);
      apb(1'b1, IDX_LINK_CTRL << 2, 32'h1);
      go <= 1'b1;
      count_to(ilas_end, n);
      count_to(dac_sample_valid, rel);
      chk(32'(dac_sample_count), 2 * nl);
      for (int k = 0; k < 2; k++)
      begin
         chk(32'(dac_sample_valid), 32'h1);
         for (int l = 0; l < nl; l++)
            chk(dac_samples[l*32 +: 32], exp_word(k, l));
         @(negedge core_clk);
      end
      apb(1'b0, IDX_LATENCY << 2, 32'h0);
      go <= 1'b0;
      lat = int'(rd[7:0]);
      chk(32'(lat < 8), 32'h1);
   endtask
   // ------------------------------
   // scenarios
   // ------------------------------
   task automatic test_regs;
      logic [31:0] lat;
      apb(1'b0, IDX_LINK_PARAMS << 2, 32'h0);
      chk(rd, PRM);
      apb(1'b0, IDX_MF_DELAY << 2, 32'h0);
      chk(rd, 32'(MF_DELAY_RST));
      apb(1'b0, IDX_VAR_BUDGET << 2, 32'h0);
      chk(rd, 32'(VAR_BUDGET_RST));
      apb(1'b1, IDX_MF_DELAY << 2, 32'ha5a5a50d);
      apb(1'b1, IDX_VAR_BUDGET << 2, 32'h5a5a5a06);
      apb(1'b0, IDX_MF_DELAY << 2, 32'h0);
      chk(rd, 32'h0000000d);
      apb(1'b0, IDX_VAR_BUDGET << 2, 32'h0);
      chk(rd, 32'h00000006);
      apb(1'b0, IDX_LATENCY << 2, 32'h0);
      lat = rd;
      apb(1'b1, IDX_LATENCY << 2, 32'h00000055);
      apb(1'b0, IDX_LATENCY << 2, 32'h0);
      chk(rd, lat);
      apb(1'b0, 16'h0c04, 32'h0);
      chk(32'(err), 32'h1);
      chk(rd, 32'h0);
      apb(1'b0, 16'h0c09, 32'h0);
      chk(32'(err), 32'h1);
      $display("test regs done");
   endtask
   task automatic test_lmfc;
      int off, per, base, n;
      for (int i = 0; i < 7; i++)
      begin
         apb(1'b1, IDX_LINK_PARAMS << 2, {PRM[31:3], 3'(FT[i])});
         apb(1'b1, IDX_MF_DELAY << 2, DT[i]);
         count_to(sysref_mf_pulse, n);
         count_to(lmfc_rx_pulse, off);
         count_to(lmfc_rx_pulse, per);
         if (DT[i] == 0)
            base = off;
         chk(per, 8 * FT[i]);
         chk(off - base, DT[i] % (8 * FT[i]));
      end
      $display("test lmfc done");
   endtask
   task automatic test_runs;
      int lat0, lat1, r0, r1, mn, mx, del;
      run_link(PRM, 0, 0, lat0, r0);  // delay zero while measuring
      run_link(PRM, 0, 0, lat1, r1);
      chk(lat1, lat0);
      chk(r1, r0);
      chk(32'(r0 >= RX_FIXED_DLY), 32'h1);
      mn = (lat1 < lat0) ? lat1 : lat0;
      mx = (lat1 > lat0) ? lat1 : lat0;
      {mn, mx} = (mx - mn >= 4) ? {mx, mn + 8} : {mn, mx};
      del = (mn + 7) % 8;
      run_link(PRM, del, (mx + 1) - (mn - 1), lat1, r1);
      chk(lat1, (lat0 - del) & 7);
      // transmitter 54 to 58 byte clocks, quarter units
      mn = (RX_FIXED_DLY * 4 + 54) / 4;
      mx = (RX_FIXED_DLY * 4 + RX_VAR_DLY * 4 + 54 + 4 + 3) / 4;
      run_link(PRM, 0, (mx + 1) - (mn - 1), lat1, r1);
      chk(r1 - r0, (mx + 1) - (mn - 1));
      run_link(PRM, 0, 12, lat1, r1);
      chk(r1 - r0, MAX_BUF_DLY);
      run_link(PRM, 0, 3, lat1, r1);
      chk(r1 - r0, 3);
      for (int i = 0; i < 3; i++)
         run_link(GOOD[i], 0, 0, lat1, r1);
      $display("test runs done");
   endtask
   task automatic test_errors;
      int n;
      for (int i = 0; i < 7; i++)
      begin
         apb(1'b1, IDX_LINK_CTRL << 2, 32'h0);
         apb(1'b1, IDX_LINK_PARAMS << 2, BAD[i]);
         apb(1'b1, IDX_LINK_CTRL << 2, 32'h1);
         go <= 1'b1;
         count_to(lane_align_config_error_flag, n);
         chk(32'(dac_sample_valid), 32'h0);
         apb(1'b0, IDX_LINK_STATUS << 2, 32'h0);
         go <= 1'b0;
         chk(32'(rd[0]), 32'h1);
         apb(1'b1, IDX_LINK_STATUS << 2, 32'h1);
         @(negedge core_clk);
         chk(32'(lane_align_config_error_flag), 32'h0);
      end
      $display("test errors done");
   endtask

   initial
   begin
      resetn     = 1'b0;
      psel       = 1'b0;
      penable    = 1'b0;
      pwrite     = 1'b0;
      paddr      = 16'h0000;
      pwdata     = 32'h0;
      go         = 1'b0;
      fail_count = 0;
      checked    = 0;
      repeat (6) @(posedge core_clk);
      resetn <= 1'b1;
      test_regs();
      test_lmfc();
      test_runs();
      test_errors();
      stop_test();
   end
endmodule // tb_top
